// ---- sim/pixel_ctrl_assertions.sv ----
module pixel_ctrl_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic power_down_n,
    input wire pixel_in_pkg::pixel_word_type out_word,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic out_enable
);
    import pixel_in_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic sw_ff;
    // a control write lets software add power-down on top of the pin, so the pin check stops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sw_ff <= 1'b0;
        else if (psel && penable && pready && pwrite && paddr == 12'h000) sw_ff <= 1'b1;
    end
    property p_answer; psel && !penable |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held");
    property p_refuse; psel && penable && pready && paddr > 12'h008 |-> pslverr; endproperty
    a_refuse: assert property (p_refuse) else $error("no error");
    property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_word); endproperty
    a_hold: assert property (p_hold) else $error("word lost");
    property p_single; out_valid && !out_word.dual |-> out_word.rgb[47:24] == 24'h00_0000;
    endproperty
    a_single: assert property (p_single) else $error("upper port used");
    property p_blank; out_valid && out_word.balanced && out_word.active
        |-> !out_word.hsync && !out_word.vsync; endproperty
    a_blank: assert property (p_blank) else $error("sync in active");
    property p_pdown; (!sw_ff && !power_down_n) [*4] |=> !out_enable; endproperty
    a_pdown: assert property (p_pdown) else $error("still driving");
    property p_reset; $rose(presetn) |-> !out_enable && !out_valid; endproperty
    a_reset: assert property (p_reset) else $error("busy after reset");
    c_dual: cover property (out_valid && out_word.dual && out_word.balanced);
    c_stall: cover property (out_valid && !out_ready);
    c_refuse: cover property (pready && pslverr);
endmodule

bind pixel_input_ctrl pixel_ctrl_checker chk (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pready, .pslverr, .power_down_n, .out_word, .out_valid, .out_ready, .out_enable);

// ---- sim/pixel_host_model.sv ----
module pixel_host_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire pixel_in_pkg::sync_pins_type level,
    output logic [23:0] pins,
    output pixel_in_pkg::sync_pins_type sync_out
);
    import pixel_in_pkg::*;
    logic [11:0] half_ff;
    // half words count up, so pairing is checkable whatever the capture phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) half_ff <= 12'h000;
        else half_ff <= half_ff + 12'h001;
    end
    assign pins = {~half_ff, half_ff}; // second port inverted copy
    assign sync_out = level;
endmodule

// ---- sim/pixel_input_ctrl_tb.sv ----
module pixel_input_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pixel_in_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic out_ready = 1'b1, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, out_valid, out_enable;
    logic [4:0] strap = 5'b0_0001; // dual, bal, edge, pol, power
    sync_pins_type lvl = '0, sync_pins;
    logic [23:0] pins;
    pixel_word_type w;
    int failures = 0, num_checks = 0;
    int pops = 0;
    initial forever #5 pclk = ~pclk;
    pixel_host_model host (.pclk, .presetn, .level(lvl), .pins, .sync_out(sync_pins));
    pixel_input_ctrl uut (.pclk, .presetn, .pixel_half_word_inputs(pins), .sync_pins,
        .port_count_strap(strap[4]), .balance_mode_strap(strap[3]),
        .capture_edge_strap(strap[2]), .enable_polarity_strap(strap[1]),
        .power_down_n(strap[0]), .double_rate_enable_or_serial_clock(1'b1),
        .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .out_word(w), .out_valid, .out_ready, .out_enable);
    // model of the word counter: every accepted word counts once
    always @(posedge pclk) begin
        if (out_valid && out_ready) pops++;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // request held until pready is sampled, then one idle edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // take words under random stalls; md is {dual, bal, edge, pol}; ph says the
    // capture phase is still the one set by reset, so rising-first pairs start even
    task automatic observe(input int n, input logic [3:0] md, input bit ph);
        logic act;
        int last;
        last = -1;
        act = lvl.de ~^ md[0];
        repeat (n) begin
            do begin
                @(posedge pclk);
                out_ready <= ($urandom_range(3, 0) != 0);
            end while (!(out_valid && out_ready));
            check(w.dual, md[3]);
            check(w.balanced, md[2]);
            check(w.active, act);
            check(w.de, lvl.de);
            check({w.hsync, w.vsync},
                (md[2] && act) ? 2'b00 : {lvl.hsync, lvl.vsync});
            check(w.rgb[23:12], 12'(w.rgb[11:0] + 12'h001));
            check(w.rgb[47:24], md[3] ? 24'(~w.rgb[23:0]) : 24'h00_0000);
            if (ph) check(w.rgb[0], md[1]);
            if (last >= 0) check((w.rgb[11:0] - last) & 1, 0);
            last = w.rgb[11:0];
        end
        @(posedge pclk);
        out_ready <= 1'b1;
    endtask
    task automatic report_and_stop;
        if (failures == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        report_and_stop;
    end
    initial begin
        void'($urandom(82500));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        check(err, 1'b1);
        // every combination of the four mode straps, power pin held high, with random sync levels
        for (int m = 0; m < 16; m++) begin
            strap <= {4'(m), 1'b1};
            lvl <= 3'($urandom);
            repeat (12) @(posedge pclk);
            observe(6, 4'(m), 1'b1);
        end
        strap[0] <= 1'b0;
        repeat (8) @(posedge pclk);
        check(out_enable, 1'b0);
        strap[0] <= 1'b1;
        // stall until the buffer refuses, then drain and clear the drop flag
        out_ready <= 1'b0;
        repeat (30) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0000_0000);
        check(rd[1:0], 2'b11);
        check(out_enable, 1'b1);
        apb(1'b0, 12'h008, 32'h0000_0000);
        check(rd, pops);
        out_ready <= 1'b1;
        repeat (10) @(posedge pclk);
        apb(1'b1, 12'h004, 32'h0000_0002);
        apb(1'b0, 12'h004, 32'h0000_0000);
        check(rd[1:0], 2'b00);
        // straps set opposite, so the words must follow the control register
        strap[4:1] <= 4'b0010;
        apb(1'b1, 12'h000, 32'h0000_000B);
        apb(1'b0, 12'h000, 32'h0000_0000);
        check(rd, 32'h0000_000B);
        repeat (12) @(posedge pclk);
        observe(6, 4'b1101, 1'b0);
        report_and_stop;
    end
endmodule

// ---- src/pixel_in_pkg.sv ----
package pixel_in_pkg;

    // one captured pixel clock: up to two ports of two half words
    typedef struct packed {
        logic [47:0] rgb;
        logic dual;
        logic balanced;
        logic active;
        logic hsync;
        logic vsync;
        logic de;
    } pixel_word_type;

    // pin-side control inputs
    typedef struct packed {
        logic hsync;
        logic vsync;
        logic de;
    } sync_pins_type;

    // mode settings as decoded from straps or register
    typedef struct packed {
        logic dual;
        logic balanced;
        logic fall_first;
        logic de_high_active;
        logic power_down_n;
    } mode_type;

endpackage

// ---- src/pixel_in_regs.svh ----
`ifndef PIXEL_IN_REGS_SVH
`define PIXEL_IN_REGS_SVH

// register byte offsets
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define COUNT_OFFSET 12'h008
`define ADDR_WIDTH 12

// control fields
`define CTRL_DUAL_BIT 0
`define CTRL_BAL_BIT 1
`define CTRL_EDGE_BIT 2
`define CTRL_POL_BIT 3
`define CTRL_PDN_BIT 4
`define CTRL_RESET 32'h0000_0000

// status fields
`define STAT_FULL_BIT 0
`define STAT_DROP_BIT 1

`endif

// ---- src/pixel_input_ctrl.sv ----
// Functional notes
// (RULE1) single port: capture only low twelve inputs
// (RULE2) dual port: low and high twelve ports
// (RULE3) port select low single, high dual
// (RULE4) host drives enable high while data valid
// (RULE5) polarity strap picks active enable level
// (RULE6) edge strap high falling first, low rising
// (RULE7) power-down low: outputs released, device idle
// (RULE8) balance strap high selects balanced encoding
// (RULE9) open straps read as low
// (RULE10) board holds double-rate enable pin high
// (RULE11) first half primary edge, second opposite edge
// (RULE12) balanced: syncs forwarded only during blanking
`include "pixel_in_regs.svh"

module pixel_input_ctrl #(
    parameter int HALF_WIDTH = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2*HALF_WIDTH-1:0] pixel_half_word_inputs,
    input wire pixel_in_pkg::sync_pins_type sync_pins,
    input wire logic port_count_strap,
    input wire logic balance_mode_strap,
    input wire logic capture_edge_strap,
    input wire logic enable_polarity_strap,
    input wire logic power_down_n,
    input wire logic double_rate_enable_or_serial_clock,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output pixel_in_pkg::pixel_word_type out_word,
    output logic out_valid,
    input wire logic out_ready,
    output logic out_enable
);
    import pixel_in_pkg::*;

    localparam int W = HALF_WIDTH;

    // two-stage sync of every pin; first stage read only by second
    logic [2*W-1:0] d_meta_ff, d_sync_ff;
    logic [2*W-1:0] dn_sync_ff;
    sync_pins_type s_meta_ff, s_sync_ff;
    logic [5:0] strap_meta_ff, strap_sync_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            d_meta_ff <= '0;
            d_sync_ff <= '0;
            s_meta_ff <= '0;
            s_sync_ff <= '0;
            strap_meta_ff <= '0; // open straps read low, see (RULE9)
            strap_sync_ff <= '0;
        end else begin
            d_meta_ff <= pixel_half_word_inputs;
            d_sync_ff <= d_meta_ff;
            s_meta_ff <= sync_pins;
            s_sync_ff <= s_meta_ff;
            strap_meta_ff <= {double_rate_enable_or_serial_clock, power_down_n,
                enable_polarity_strap, capture_edge_strap, balance_mode_strap,
                port_count_strap};
            strap_sync_ff <= strap_meta_ff;
        end
    end

    // one clock only: the primary half is the older of two samples and the
    // opposite half the next one; d_sync_ff is already safe, so one stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dn_sync_ff <= '0;
        end else begin
            dn_sync_ff <= d_sync_ff;
        end
    end

    // software control overrides nothing until written; straps are default
    logic [31:0] ctrl_ff;
    logic use_reg_ff;
    logic drop_ff;
    logic [31:0] count_ff;
    mode_type mode;

    always_comb begin
        mode.dual = use_reg_ff ? ctrl_ff[`CTRL_DUAL_BIT] : strap_sync_ff[0];
        mode.balanced = use_reg_ff ? ctrl_ff[`CTRL_BAL_BIT] : strap_sync_ff[1];
        mode.fall_first = use_reg_ff ? ctrl_ff[`CTRL_EDGE_BIT] : strap_sync_ff[2];
        mode.de_high_active = use_reg_ff ? ctrl_ff[`CTRL_POL_BIT] : strap_sync_ff[3];
        // power-down pin always wins; register can only add power-down
        mode.power_down_n = strap_sync_ff[4] & ~(use_reg_ff & ctrl_ff[`CTRL_PDN_BIT]);
    end

    // data active by selected enable level
    logic de_active;
    assign de_active = mode.de_high_active ? s_sync_ff.de : ~s_sync_ff.de; // see (RULE5) (RULE4)

    // assemble one pixel word from the two halves
    logic [W-1:0] first_lo, second_lo, first_hi, second_hi;
    pixel_word_type word_in;

    always_comb begin
        // primary half is the older sample, opposite half the next, see (RULE11)
        first_lo = dn_sync_ff[W-1:0];
        second_lo = d_sync_ff[W-1:0];
        first_hi = dn_sync_ff[2*W-1:W];
        second_hi = d_sync_ff[2*W-1:W];
        word_in = '0;
        word_in.rgb[2*W-1:0] = {second_lo, first_lo}; // see (RULE1)
        if (mode.dual) begin
            word_in.rgb[4*W-1:2*W] = {second_hi, first_hi}; // see (RULE2) (RULE3)
        end
        word_in.dual = mode.dual;
        word_in.balanced = mode.balanced; // see (RULE8)
        word_in.active = de_active;
        word_in.de = s_sync_ff.de;
        // balanced link carries controls only in blanking, see (RULE12)
        if (!mode.balanced || !de_active) begin
            word_in.hsync = s_sync_ff.hsync;
            word_in.vsync = s_sync_ff.vsync;
        end
    end

    // capture every other cycle so the two halves pair up cleanly
    logic phase_ff;
    logic in_valid;
    // edge strap shifts the pairing by one sample; flipping it mid-stream
    // may pair one half twice, so set it while the host is idle
    assign in_valid = (phase_ff ^ mode.fall_first) & mode.power_down_n; // see (RULE6)

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_ff <= 1'b0;
        end else if (!mode.power_down_n) begin
            phase_ff <= 1'b0; // see (RULE7)
        end else begin
            phase_ff <= ~phase_ff;
        end
    end

    // two-entry skid buffer; a word arriving while it is full is dropped and sets drop_ff
    pixel_word_type buf_ff [2];
    logic [1:0] cnt_ff;
    logic rd_ptr_ff, wr_ptr_ff;
    logic in_ready;
    logic push, pop;
    assign in_ready = (cnt_ff != 2'd2);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
            rd_ptr_ff <= 1'b0;
            wr_ptr_ff <= 1'b0;
            buf_ff[0] <= '0;
            buf_ff[1] <= '0;
        end else if (!mode.power_down_n) begin
            cnt_ff <= '0; // see (RULE7)
            rd_ptr_ff <= 1'b0;
            wr_ptr_ff <= 1'b0;
        end else begin
            if (push) begin
                buf_ff[wr_ptr_ff] <= word_in;
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end

    // registered output view of the buffer head
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_word <= '0;
            out_valid <= 1'b0;
            out_enable <= 1'b0;
        end else begin
            out_enable <= mode.power_down_n; // outputs released at power-down, see (RULE7)
            if (!out_valid || out_ready) begin
                out_valid <= 1'b0;
                if (cnt_ff != 2'd0 && mode.power_down_n && !(out_valid && cnt_ff == 2'd1)) begin
                    out_word <= out_valid ? buf_ff[~rd_ptr_ff] : buf_ff[rd_ptr_ff];
                    out_valid <= 1'b1;
                end
            end
            if (!mode.power_down_n) begin
                out_valid <= 1'b0;
            end
        end
    end

    // word counter and drop flag; drop set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= '0;
            drop_ff <= 1'b0;
        end else begin
            if (pop) begin
                count_ff <= count_ff + 32'h0000_0001;
            end
            if (in_valid && !in_ready) begin
                drop_ff <= 1'b1;
            end else if (psel && penable && pwrite && paddr == `STATUS_OFFSET
                    && pwdata[`STAT_DROP_BIT]) begin
                drop_ff <= 1'b0;
            end
        end
    end

    // apb slave: zero-wait, error on unmapped address
    logic hit;
    assign hit = (paddr == `CTRL_OFFSET) || (paddr == `STATUS_OFFSET)
        || (paddr == `COUNT_OFFSET);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `CTRL_RESET;
            use_reg_ff <= 1'b0;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            if (psel && penable && pwrite && paddr == `CTRL_OFFSET) begin
                ctrl_ff <= pwdata;
                use_reg_ff <= 1'b1;
            end
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `CTRL_OFFSET: prdata <= ctrl_ff;
                    `STATUS_OFFSET: prdata <= {30'h0, drop_ff, cnt_ff == 2'd2};
                    `COUNT_OFFSET: prdata <= count_ff;
                    default: prdata <= '0;
                endcase
            end
        end
    end

endmodule
